// >>> src/eaxc_defines.svh
// Constants for the effective-address and exception-check block
`ifndef EAXC_DEFINES_SVH
`define EAXC_DEFINES_SVH
`define EAXC_OP_TWI 6'h03
`define EAXC_OP_SC 6'h11
`define EAXC_OP_B 6'h12
`define EAXC_OP_X19 6'h13
`define EAXC_OP_X31 6'h1f
`define EAXC_OP_X59 6'h3b
`define EAXC_OP_X63 6'h3f
`define EAXC_XO_RFI 10'h032
`define EAXC_XO_ISYNC 10'h096
`define EAXC_XO_BCLR 10'h010
`define EAXC_XO_BCCTR 10'h210
`define EAXC_XO_TW 10'h004
`define EAXC_XO_MFMSR 10'h053
`define EAXC_XO_MTMSR 10'h092
`define EAXC_XO_MFSPR 10'h153
`define EAXC_XO_MTSPR 10'h1d3
`define EAXC_XO_MFTB 10'h173
`define EAXC_XO_MFSR 10'h253
`define EAXC_XO_MFSRIN 10'h293
`define EAXC_XO_MTSR 10'h0d2
`define EAXC_XO_MTSRIN 10'h0f2
`define EAXC_XO_DCBI 10'h1d6
`define EAXC_XO_TLBIE 10'h132
`define EAXC_XO_TLBSYNC 10'h236
`define EAXC_XO_TLBIA 10'h172
`define EAXC_XO_SYNC 10'h256
`define EAXC_XO_FSQRT 5'h16
`define EAXC_SPR_XER 10'h001
`define EAXC_SPR_LR 10'h008
`define EAXC_SPR_CTR 10'h009
`define EAXC_SPR_PVR 10'h11f
`define EAXC_SPR_HARDWARE_IMPL_REG_1 10'h3f5
`define EAXC_TBR_TBL 10'h10c
`define EAXC_TBR_TBU 10'h10d
`endif

// >>> src/eaxc_pkg.sv
// Types for the effective-address and exception-check block
package eaxc_pkg;
  typedef enum logic [2:0] {
    EAXC_CAUSE_NONE = 3'h0,
    EAXC_CAUSE_IFETCH = 3'h1,
    EAXC_CAUSE_ILLEGAL = 3'h2,
    EAXC_CAUSE_PRIV = 3'h3,
    EAXC_CAUSE_TRAP = 3'h4,
    EAXC_CAUSE_SYSCALL = 3'h5,
    EAXC_CAUSE_FP = 3'h6,
    EAXC_CAUSE_DACCESS = 3'h7
  } eaxc_cause_t;
  typedef enum logic [1:0] {
    EAXC_BR_IMM = 2'h0,
    EAXC_BR_LINK = 2'h1,
    EAXC_BR_COUNT = 2'h2,
    EAXC_BR_SEQ = 2'h3
  } eaxc_br_src_t;
  typedef enum logic [1:0] {
    EAXC_ST_IDLE = 2'h0,
    EAXC_ST_DRAIN = 2'h1,
    EAXC_ST_ISSUE = 2'h2
  } eaxc_state_t;
endpackage

// >>> src/eaxc_core.sv
// Effective address generation and instruction exception checking
`timescale 1ns/1ps
`default_nettype none
`include "eaxc_defines.svh"
module eaxc_core #(
  parameter int AW = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic insn_valid,
  input wire logic [31:0] insn_word,
  input wire logic [AW-1:0] insn_addr,
  input wire logic [AW-1:0] base_reg_operand,
  input wire logic [AW-1:0] index_reg_operand,
  input wire logic [AW-1:0] link_reg,
  input wire logic [AW-1:0] count_reg,
  input wire logic [3:0] mem_len,
  input wire logic is_mem_access,
  input wire logic use_index,
  input wire eaxc_pkg::eaxc_br_src_t br_src,
  input wire logic user_mode_bit,
  input wire logic fp_exc_enable,
  input wire logic fp_exc_cond,
  input wire logic trap_cond,
  input wire logic ifetch_page_fault,
  input wire logic data_page_fault,
  input wire logic little_endian_sel,
  input wire logic older_drained,
  output logic [AW-1:0] data_ea,
  output logic [AW-1:0] branch_ea,
  output logic [AW-1:0] next_seq_ea,
  output logic [AW-1:0] last_byte_ea,
  output logic wraps,
  output logic misaligned,
  output logic big_endian,
  output logic dispatch_ready,
  output logic complete_ready,
  output logic exc_valid,
  output eaxc_pkg::eaxc_cause_t exc_cause,
  output logic cr_update,
  output logic xer_ov_update,
  output logic spr_write_en
);
  logic [5:0] opcd;
  logic [9:0] xo;
  logic [4:0] xo5;
  logic [9:0] sprn;
  logic [4:0] ra_field;
  logic [AW-1:0] base_val, offset_val, br_imm, seq_sum;
  logic [AW:0] end_sum;
  logic is_x31, is_x19, is_fp;
  logic illegal, priv, spr_bad, spr_super, spr_ro, sync_ctx, sync_exec;
  logic barrier;
  logic endian_le_reg;
  eaxc_pkg::eaxc_cause_t cause_next;
  eaxc_pkg::eaxc_state_t state_reg, state_next;

  assign opcd = insn_word[31:26];
  assign xo = insn_word[10:1];
  assign xo5 = insn_word[5:1];
  assign ra_field = insn_word[20:16];
  // Split halves of the register number are swapped in the encoding
  assign sprn = {insn_word[15:11], insn_word[20:16]};
  assign is_x31 = (opcd == `EAXC_OP_X31);
  assign is_x19 = (opcd == `EAXC_OP_X19);
  assign is_fp = (opcd == `EAXC_OP_X59) || (opcd == `EAXC_OP_X63);

  // Base of zero when the field names register zero
  assign base_val = (ra_field == 5'h00) ? '0 : base_reg_operand;
  assign offset_val = use_index ? index_reg_operand
                    : {{(AW-16){insn_word[15]}}, insn_word[15:0]};
  // Carry out of the top bit dropped by the width of the sum
  assign data_ea = base_val + offset_val;
  assign br_imm = {{(AW-26){insn_word[25]}}, insn_word[25:2], 2'b00};
  assign seq_sum = insn_addr + AW'(4);
  assign next_seq_ea = seq_sum;

  always_comb begin
    unique case (br_src)
      eaxc_pkg::EAXC_BR_IMM: branch_ea = insn_word[1] ? br_imm
                                         : insn_addr + br_imm;
      eaxc_pkg::EAXC_BR_LINK: branch_ea = {link_reg[AW-1:2], 2'b00};
      eaxc_pkg::EAXC_BR_COUNT: branch_ea = {count_reg[AW-1:2], 2'b00};
      eaxc_pkg::EAXC_BR_SEQ: branch_ea = seq_sum;
    endcase
  end

  // Length is supplied by decode of the instruction itself
  assign end_sum = {1'b0, data_ea} + {{(AW-3){1'b0}}, mem_len};
  assign last_byte_ea = data_ea + AW'(mem_len) - AW'(1);
  assign wraps = is_mem_access && end_sum[AW]
                 && (end_sum[AW-1:0] != '0);
  always_comb begin
    unique case (mem_len)
      4'h1: misaligned = 1'b0;
      4'h2: misaligned = data_ea[0];
      4'h4: misaligned = |data_ea[1:0];
      4'h8: misaligned = |data_ea[2:0];
      default: misaligned = 1'b0;
    endcase
  end

  // Reset default is big-endian
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      endian_le_reg <= 1'b0;
    end else begin
      endian_le_reg <= little_endian_sel;
    end
  end
  assign big_endian = !endian_le_reg;

  always_comb begin
    spr_bad = 1'b0;
    spr_super = 1'b0;
    spr_ro = 1'b0;
    if (is_x31 && (xo == `EAXC_XO_MFTB)) begin
      spr_bad = (sprn != `EAXC_TBR_TBL) && (sprn != `EAXC_TBR_TBU);
    end else if (is_x31 && (xo == `EAXC_XO_MFSPR || xo == `EAXC_XO_MTSPR)) begin
      // Bit 4 of the number marks supervisor-level registers
      spr_super = sprn[4];
      spr_ro = (xo == `EAXC_XO_MTSPR)
               && (sprn == `EAXC_SPR_HARDWARE_IMPL_REG_1 || sprn == `EAXC_SPR_PVR);
      spr_bad = !sprn[4] && (sprn != `EAXC_SPR_XER)
                && (sprn != `EAXC_SPR_LR)
                && (sprn != `EAXC_SPR_CTR);
    end
  end

  always_comb begin
    illegal = 1'b0;
    priv = 1'b0;
    if (insn_word == 32'h0000_0000) illegal = 1'b1;
    unique case (opcd)
      6'h01, 6'h04, 6'h05, 6'h06, 6'h09, 6'h16, 6'h38, 6'h3c, 6'h3d:
        illegal = 1'b1;
      6'h02, 6'h1e, 6'h3a, 6'h3e: illegal = 1'b1;
      default: ;
    endcase
    if (is_fp && xo5 == `EAXC_XO_FSQRT) illegal = 1'b1;
    if (is_x31 && xo == `EAXC_XO_TLBIA) illegal = 1'b1;
    if (spr_bad) illegal = 1'b1;
    if (is_x31) begin
      unique case (xo)
        `EAXC_XO_DCBI, `EAXC_XO_MFMSR, `EAXC_XO_MTMSR, `EAXC_XO_MFSR,
        `EAXC_XO_MFSRIN, `EAXC_XO_MTSR, `EAXC_XO_MTSRIN,
        `EAXC_XO_TLBIE, `EAXC_XO_TLBSYNC: priv = user_mode_bit;
        `EAXC_XO_MFSPR, `EAXC_XO_MTSPR: priv = user_mode_bit && spr_super;
        default: ;
      endcase
    end
    if (is_x19 && xo == `EAXC_XO_RFI) priv = user_mode_bit;
  end

  // Supervisor write to a read-only register is dropped silently
  assign spr_write_en = insn_valid && is_x31 && (xo == `EAXC_XO_MTSPR)
                        && !illegal && !priv && !spr_ro;

  // Only the top cause leaves; fetch fault outranks decode faults
  always_comb begin
    cause_next = eaxc_pkg::EAXC_CAUSE_NONE;
    if (ifetch_page_fault) cause_next = eaxc_pkg::EAXC_CAUSE_IFETCH;
    else if (illegal) cause_next = eaxc_pkg::EAXC_CAUSE_ILLEGAL;
    else if (priv) cause_next = eaxc_pkg::EAXC_CAUSE_PRIV;
    else if (opcd == `EAXC_OP_SC) cause_next = eaxc_pkg::EAXC_CAUSE_SYSCALL;
    else if (trap_cond && (opcd == `EAXC_OP_TWI
             || (is_x31 && xo == `EAXC_XO_TW)))
      cause_next = eaxc_pkg::EAXC_CAUSE_TRAP;
    else if (fp_exc_cond && fp_exc_enable)
      cause_next = eaxc_pkg::EAXC_CAUSE_FP;
    else if (data_page_fault && is_mem_access)
      cause_next = eaxc_pkg::EAXC_CAUSE_DACCESS;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      exc_valid <= 1'b0;
      exc_cause <= eaxc_pkg::EAXC_CAUSE_NONE;
    end else begin
      exc_valid <= insn_valid && dispatch_ready
                   && (cause_next != eaxc_pkg::EAXC_CAUSE_NONE);
      exc_cause <= (insn_valid && dispatch_ready) ? cause_next
                   : eaxc_pkg::EAXC_CAUSE_NONE;
    end
  end

  // Record and overflow forms only; faulting instructions update neither flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cr_update <= 1'b0;
      xer_ov_update <= 1'b0;
    end else begin
      cr_update <= insn_valid && dispatch_ready && insn_word[0]
                   && (is_x31 || is_fp)
                   && (cause_next == eaxc_pkg::EAXC_CAUSE_NONE);
      xer_ov_update <= insn_valid && dispatch_ready && is_x31
                       && insn_word[10]
                       && (cause_next == eaxc_pkg::EAXC_CAUSE_NONE);
    end
  end

  // Context sync: sc, rfi. Exec sync start: mtmsr. Barriers: sync, isync.
  assign sync_ctx = (opcd == `EAXC_OP_SC)
                    || (is_x19 && xo == `EAXC_XO_RFI);
  // Machine state write waits for drain but changes no fetch context
  assign sync_exec = is_x31 && (xo == `EAXC_XO_MTMSR);
  assign barrier = (is_x31 && xo == `EAXC_XO_SYNC)
                   || (is_x19 && xo == `EAXC_XO_ISYNC);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      eaxc_pkg::EAXC_ST_IDLE:
        if (insn_valid && (sync_ctx || sync_exec) && !older_drained)
          state_next = eaxc_pkg::EAXC_ST_DRAIN;
      eaxc_pkg::EAXC_ST_DRAIN:
        if (older_drained) state_next = eaxc_pkg::EAXC_ST_ISSUE;
      eaxc_pkg::EAXC_ST_ISSUE:
        state_next = eaxc_pkg::EAXC_ST_IDLE;
      default: state_next = eaxc_pkg::EAXC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) state_reg <= eaxc_pkg::EAXC_ST_IDLE;
    else state_reg <= state_next;
  end

  // Dispatch holds while a synchronizing instruction waits to start
  assign dispatch_ready = !((sync_ctx || sync_exec) && insn_valid)
                          || older_drained;
  // Barriers may start early but finish only after the drain
  assign complete_ready = !(barrier && insn_valid) || older_drained;

  a_ea_sum_wrap: assert property (@(posedge clk) disable iff (!resetn)
    data_ea == AW'(base_val + offset_val))
    else $error("Effective address sum wrong");
  a_base_zero: assert property (@(posedge clk) disable iff (!resetn)
    (ra_field == 5'h00 && use_index) |-> data_ea == index_reg_operand)
    else $error("Base register zero not treated as zero");
  a_align_word: assert property (@(posedge clk) disable iff (!resetn)
    (mem_len == 4'h4) |-> misaligned == (data_ea[1:0] != 2'b00))
    else $error("Word alignment misclassified");
  a_ctx_wait: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && sync_ctx && !older_drained) |-> !dispatch_ready)
    else $error("Context sync issued before drain");
  a_barrier_hold: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && barrier && !older_drained) |-> !complete_ready)
    else $error("Barrier completed before drain");
  a_zero_illegal: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && dispatch_ready && insn_word == 32'h0
     && !ifetch_page_fault)
    |=> exc_valid && exc_cause == eaxc_pkg::EAXC_CAUSE_ILLEGAL)
    else $error("Zero word not illegal");
  a_sc_raise: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && dispatch_ready && insn_word[31:26] == `EAXC_OP_SC
     && !ifetch_page_fault)
    |=> exc_cause == eaxc_pkg::EAXC_CAUSE_SYSCALL)
    else $error("System call not raised");
  a_fp_gate: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && !fp_exc_enable) |=> exc_cause != eaxc_pkg::EAXC_CAUSE_FP)
    else $error("FP exception while disabled");
  a_ro_noop: assert property (@(posedge clk) disable iff (!resetn)
    spr_ro |-> !spr_write_en)
    else $error("Read-only register written");
  a_endian_reset: assert property (@(posedge clk)
    $rose(resetn) |-> big_endian)
    else $error("Not big-endian after reset");
  a_exc_clean: assert property (@(posedge clk) disable iff (!resetn)
    exc_valid |-> !cr_update && !xer_ov_update)
    else $error("Faulting instruction updated state");
  // Last word of the space must roll over to the bottom
  a_seq_next: assert property (@(posedge clk) disable iff (!resetn)
    (&insn_addr[AW-1:2])
    |-> next_seq_ea == {{(AW-2){1'b0}}, insn_addr[1:0]})
    else $error("Sequential address did not roll over");
  a_wrap_top: assert property (@(posedge clk) disable iff (!resetn)
    (is_mem_access && (&data_ea) && mem_len == 4'h2) |-> wraps)
    else $error("Operand past top address did not wrap");
  a_no_wrap: assert property (@(posedge clk) disable iff (!resetn)
    !is_mem_access |-> !wraps)
    else $error("Wrap flagged without memory access");
  a_last_byte: assert property (@(posedge clk) disable iff (!resetn)
    (mem_len == 4'h1) |-> last_byte_ea == data_ea)
    else $error("Byte operand last address wrong");
  a_br_link: assert property (@(posedge clk) disable iff (!resetn)
    (br_src == eaxc_pkg::EAXC_BR_LINK)
    |-> branch_ea[AW-1:2] == link_reg[AW-1:2])
    else $error("Link target wrong");
  a_br_count: assert property (@(posedge clk) disable iff (!resetn)
    (br_src == eaxc_pkg::EAXC_BR_COUNT)
    |-> branch_ea[AW-1:2] == count_reg[AW-1:2])
    else $error("Count target wrong");
  a_msr_wait: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && sync_exec && !older_drained) |-> !dispatch_ready)
    else $error("Machine state write issued before drain");
  a_illegal_op: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && dispatch_ready && opcd == 6'h01 && !ifetch_page_fault)
    |=> exc_cause == eaxc_pkg::EAXC_CAUSE_ILLEGAL)
    else $error("Undefined opcode not illegal");
  a_op64_illegal: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && dispatch_ready && opcd == 6'h3e && !ifetch_page_fault)
    |=> exc_cause == eaxc_pkg::EAXC_CAUSE_ILLEGAL)
    else $error("Wide-only opcode not illegal");
  a_tlbia_illegal: assert property (@(posedge clk) disable iff (!resetn)
    (is_x31 && xo == `EAXC_XO_TLBIA) |-> illegal)
    else $error("Unimplemented invalidate-all not illegal");
  a_priv_user: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && dispatch_ready && user_mode_bit && is_x31
     && xo == `EAXC_XO_MFMSR && !ifetch_page_fault)
    |=> exc_cause == eaxc_pkg::EAXC_CAUSE_PRIV)
    else $error("User state read not privileged");
  a_priv_super: assert property (@(posedge clk) disable iff (!resetn)
    !user_mode_bit |-> !priv)
    else $error("Privilege fault in supervisor mode");
  a_spr_user: assert property (@(posedge clk) disable iff (!resetn)
    (is_x31 && xo == `EAXC_XO_MFSPR && sprn == `EAXC_SPR_LR)
    |-> !priv && !illegal)
    else $error("User register read faulted");
  a_tb_bad: assert property (@(posedge clk) disable iff (!resetn)
    (is_x31 && xo == `EAXC_XO_MFTB && sprn == 10'h000) |-> illegal)
    else $error("Bad time-base field not illegal");
  a_fetch_first: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && dispatch_ready && ifetch_page_fault)
    |=> exc_cause == eaxc_pkg::EAXC_CAUSE_IFETCH)
    else $error("Fetch fault not reported");
  a_trap_raise: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && dispatch_ready && trap_cond
     && opcd == `EAXC_OP_TWI && !ifetch_page_fault)
    |=> exc_cause == eaxc_pkg::EAXC_CAUSE_TRAP)
    else $error("Satisfied trap not raised");
  a_cr_record: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && dispatch_ready && !insn_word[0]) |=> !cr_update)
    else $error("Condition update without record form");
  a_ov_plain: assert property (@(posedge clk) disable iff (!resetn)
    (insn_valid && dispatch_ready && !insn_word[10]) |=> !xer_ov_update)
    else $error("Overflow update without overflow form");
  a_exc_idle: assert property (@(posedge clk) disable iff (!resetn)
    !insn_valid |=> !exc_valid)
    else $error("Exception without an instruction");

  c_wrap: cover property (@(posedge clk) disable iff (!resetn) wraps);
  c_priv: cover property (@(posedge clk) disable iff (!resetn)
    exc_cause == eaxc_pkg::EAXC_CAUSE_PRIV);
  c_drain: cover property (@(posedge clk) disable iff (!resetn)
    state_reg == eaxc_pkg::EAXC_ST_DRAIN ##1
    state_reg == eaxc_pkg::EAXC_ST_ISSUE);
  c_trap: cover property (@(posedge clk) disable iff (!resetn)
    exc_cause == eaxc_pkg::EAXC_CAUSE_TRAP);
endmodule
`default_nettype wire

// >>> verif/eaxc_pipe_model.sv
// Model of older in-flight work that reports when it has drained
`timescale 1ns/1ps
`default_nettype none
module eaxc_pipe_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] hold,
  output logic older_drained
);
  logic [7:0] cnt_reg;
  // Older work stays in flight for hold cycles after start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 8'h00;
    end else if (start) begin
      cnt_reg <= hold;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  assign older_drained = (cnt_reg == 8'h00) && !start;
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the address and exception block
`timescale 1ns/1ps
`default_nettype none
`include "eaxc_defines.svh"
module testbench;
  logic clk, resetn, insn_valid, is_mem_access, use_index, user_mode_bit;
  logic fp_exc_enable, fp_exc_cond, trap_cond, ifetch_page_fault;
  logic data_page_fault, little_endian_sel, older_drained, start;
  logic wraps, misaligned, big_endian, dispatch_ready, complete_ready;
  logic exc_valid, cr_update, xer_ov_update, spr_write_en;
  logic [7:0] hold;
  logic [31:0] insn_word, insn_addr, base_reg_operand, index_reg_operand;
  logic [31:0] link_reg, count_reg, data_ea, branch_ea, next_seq_ea;
  logic [31:0] last_byte_ea;
  logic [3:0] mem_len;
  eaxc_pkg::eaxc_br_src_t br_src;
  eaxc_pkg::eaxc_cause_t exc_cause;
  int mismatches, n_tests, waited;
  eaxc_core u_eaxc_core (.clk(clk), .resetn(resetn),
    .insn_valid(insn_valid), .insn_word(insn_word), .insn_addr(insn_addr),
    .base_reg_operand(base_reg_operand), .index_reg_operand(index_reg_operand),
    .link_reg(link_reg), .count_reg(count_reg), .mem_len(mem_len),
    .is_mem_access(is_mem_access), .use_index(use_index), .br_src(br_src),
    .user_mode_bit(user_mode_bit), .fp_exc_enable(fp_exc_enable),
    .fp_exc_cond(fp_exc_cond), .trap_cond(trap_cond),
    .ifetch_page_fault(ifetch_page_fault), .data_page_fault(data_page_fault),
    .little_endian_sel(little_endian_sel), .older_drained(older_drained),
    .data_ea(data_ea), .branch_ea(branch_ea), .next_seq_ea(next_seq_ea),
    .last_byte_ea(last_byte_ea), .wraps(wraps), .misaligned(misaligned),
    .big_endian(big_endian), .dispatch_ready(dispatch_ready),
    .complete_ready(complete_ready), .exc_valid(exc_valid),
    .exc_cause(exc_cause), .cr_update(cr_update),
    .xer_ov_update(xer_ov_update), .spr_write_en(spr_write_en));
  eaxc_pipe_model u_eaxc_pipe_model (.clk(clk), .resetn(resetn),
    .start(start), .hold(hold), .older_drained(older_drained));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Present on an edge, then look at combinational outputs mid-cycle
  task automatic present(input logic [31:0] w);
    @(posedge clk);
    insn_word <= w;
    insn_valid <= 1'b1;
    @(negedge clk);
  endtask
  // Bounded wait for the handshake; a stuck ready counts as a mismatch
  task automatic take();
    waited = 0;
    while (dispatch_ready !== 1'b1 && waited < 100) begin
      @(negedge clk);
      waited++;
    end
    if (waited == 100) chk(32'(waited), 32'h0);
    @(posedge clk);
    insn_valid <= 1'b0;
    #1;
  endtask
  task automatic xc(input logic [31:0] w, input eaxc_pkg::eaxc_cause_t c);
    present(w);
    take();
    chk({31'h0, exc_valid}, {31'h0, c != eaxc_pkg::EAXC_CAUSE_NONE});
    chk({29'h0, exc_cause}, {29'h0, c});
  endtask
  function automatic logic [31:0] x(input logic [5:0] op, input logic [9:0] xo);
    return {op, 15'h0, xo, 1'b0};
  endfunction
  function automatic logic [31:0] special_purpose_reg(input logic [9:0] xo, input logic [9:0] n);
    return {6'h1f, 5'h03, n[4:0], n[9:5], xo, 1'b0};
  endfunction
  task automatic ea_case(input logic [31:0] w, b, i, input logic [3:0] len,
      input logic ui, input logic [31:0] ea, last, input logic wr, mis);
    base_reg_operand <= b;
    index_reg_operand <= i;
    mem_len <= len;
    use_index <= ui;
    present(w);
    chk(data_ea, ea);
    chk(last_byte_ea, last);
    chk({31'h0, wraps}, {31'h0, wr});
    chk({31'h0, misaligned}, {31'h0, mis});
    take();
  endtask
  task automatic t_ea();
    is_mem_access <= 1'b1;
    ea_case({6'h20, 10'h043, 16'hfffc}, 32'h1000, 0, 4, 0, 32'hffc, 32'hfff, 0, 0);
    ea_case({6'h20, 10'h040, 16'h0008}, 32'h12345678, 0, 4, 0, 8, 32'hb, 0, 0);
    ea_case(x(6'h1f, 10'h017) | 32'h30000, 32'hfffffff0, 32'h14, 4, 1, 4, 7, 0, 0);
    ea_case(x(6'h1f, 10'h017), 32'h9, 32'h14, 2, 1, 32'h14, 32'h15, 0, 0);
    ea_case({6'h20, 10'h043, 16'h0}, 32'hfffffffe, 0, 4, 0, 32'hfffffffe, 1, 1, 1);
    ea_case({6'h20, 10'h043, 16'h0}, 32'hfffffffe, 0, 2, 0, 32'hfffffffe, 32'hffffffff, 0, 0);
    is_mem_access <= 1'b0;
  endtask
  task automatic t_branch();
    insn_addr <= 32'hfffffff0;
    br_src <= eaxc_pkg::EAXC_BR_IMM;
    present({6'h12, 24'h000008, 2'b00});
    chk(branch_ea, 32'h10);
    take();
    present({6'h12, 24'h000040, 2'b10});
    chk(branch_ea, 32'h100);
    take();
    br_src <= eaxc_pkg::EAXC_BR_LINK;
    present(x(6'h13, 10'h010));
    chk(branch_ea, link_reg);
    take();
    br_src <= eaxc_pkg::EAXC_BR_COUNT;
    insn_addr <= 32'hfffffffc;
    present(x(6'h13, 10'h210));
    chk(branch_ea, count_reg);
    chk(next_seq_ea, 32'h0);
    take();
    br_src <= eaxc_pkg::EAXC_BR_SEQ;
  endtask
  task automatic t_exc();
    logic [9:0] priv [9];
    priv = '{10'h053, 10'h092, 10'h253, 10'h293, 10'h0d2, 10'h0f2, 10'h1d6,
             10'h132, 10'h236};
    user_mode_bit <= 1'b1;
    xc(32'h0, eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    xc({6'h02, 26'h0}, eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    xc({6'h1e, 26'h0}, eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    xc({6'h3a, 26'h0}, eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    xc({6'h3e, 26'h0}, eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    xc({6'h01, 26'h0}, eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    xc({6'h3f, 20'h0, 5'h16, 1'b0}, eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    xc({6'h3b, 20'h0, 5'h16, 1'b0}, eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    xc(x(6'h1f, 10'h172), eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    xc({6'h11, 24'h0, 2'b10}, eaxc_pkg::EAXC_CAUSE_SYSCALL);
    foreach (priv[k]) xc(x(6'h1f, priv[k]), eaxc_pkg::EAXC_CAUSE_PRIV);
    xc(x(6'h13, 10'h032), eaxc_pkg::EAXC_CAUSE_PRIV);
    xc(special_purpose_reg(10'h153, 10'h008), eaxc_pkg::EAXC_CAUSE_NONE);
    xc(special_purpose_reg(10'h153, 10'h11f), eaxc_pkg::EAXC_CAUSE_PRIV);
    xc(special_purpose_reg(10'h153, 10'h000), eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    xc(special_purpose_reg(10'h173, 10'h10c), eaxc_pkg::EAXC_CAUSE_NONE);
    xc(special_purpose_reg(10'h173, 10'h000), eaxc_pkg::EAXC_CAUSE_ILLEGAL);
    trap_cond <= 1'b1;
    xc({6'h03, 26'h0}, eaxc_pkg::EAXC_CAUSE_TRAP);
    trap_cond <= 1'b0;
    xc({6'h03, 26'h0}, eaxc_pkg::EAXC_CAUSE_NONE);
    fp_exc_cond <= 1'b1;
    xc({6'h3f, 20'h0, 5'h15, 1'b0}, eaxc_pkg::EAXC_CAUSE_NONE);
    fp_exc_enable <= 1'b1;
    xc({6'h3f, 20'h0, 5'h15, 1'b0}, eaxc_pkg::EAXC_CAUSE_FP);
    fp_exc_cond <= 1'b0;
    ifetch_page_fault <= 1'b1;
    xc(32'h0, eaxc_pkg::EAXC_CAUSE_IFETCH);
    ifetch_page_fault <= 1'b0;
    data_page_fault <= 1'b1;
    is_mem_access <= 1'b1;
    xc({6'h20, 26'h0}, eaxc_pkg::EAXC_CAUSE_DACCESS);
    data_page_fault <= 1'b0;
    is_mem_access <= 1'b0;
    user_mode_bit <= 1'b0;
    xc(x(6'h1f, 10'h053), eaxc_pkg::EAXC_CAUSE_NONE);
    present(special_purpose_reg(10'h1d3, 10'h3f5));
    chk({31'h0, spr_write_en}, 0);
    take();
    chk({31'h0, exc_valid}, 0);
    present(special_purpose_reg(10'h1d3, 10'h008));
    chk({31'h0, spr_write_en}, 1);
    take();
  endtask
  task automatic t_flags();
    present({6'h1f, 15'h0, 1'b0, 9'h10a, 1'b1});
    take();
    chk({30'h0, cr_update, xer_ov_update}, 32'h2);
    present({6'h1f, 15'h0, 1'b1, 9'h10a, 1'b0});
    take();
    chk({30'h0, cr_update, xer_ov_update}, 32'h1);
  endtask
  // Older work held in flight for six cycles around each ordering case
  task automatic drain(input logic [31:0] w, input logic dw, cr0,
      input eaxc_pkg::eaxc_cause_t c);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    insn_word <= w;
    insn_valid <= 1'b1;
    @(negedge clk);
    if (cr0) chk({31'h0, complete_ready}, 0);
    take();
    if (dw) chk({31'h0, waited >= 6}, 1);
    chk({29'h0, exc_cause}, {29'h0, c});
  endtask
  task automatic t_endian();
    chk({31'h0, big_endian}, 1);
    little_endian_sel <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, big_endian}, 0);
    little_endian_sel <= 1'b0;
  endtask
  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    {resetn, insn_valid, is_mem_access, use_index, user_mode_bit} = 0;
    {fp_exc_enable, fp_exc_cond, trap_cond, ifetch_page_fault} = 0;
    {data_page_fault, little_endian_sel, start} = 0;
    hold = 8'h06;
    insn_word = 0;
    insn_addr = 32'h100;
    base_reg_operand = 0;
    index_reg_operand = 0;
    link_reg = 32'h2000;
    count_reg = 32'h3000;
    mem_len = 4'h4;
    br_src = eaxc_pkg::EAXC_BR_SEQ;
    mismatches = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    t_endian();
    t_ea();
    t_branch();
    t_exc();
    t_flags();
    drain({6'h11, 24'h0, 2'b10}, 1, 0, eaxc_pkg::EAXC_CAUSE_SYSCALL);
    drain(x(6'h13, 10'h032), 1, 0, eaxc_pkg::EAXC_CAUSE_NONE);
    drain(x(6'h1f, 10'h092), 1, 0, eaxc_pkg::EAXC_CAUSE_NONE);
    drain(x(6'h1f, 10'h256), 0, 1, eaxc_pkg::EAXC_CAUSE_NONE);
    drain(x(6'h13, 10'h096), 0, 1, eaxc_pkg::EAXC_CAUSE_NONE);
    report_and_stop();
  end
endmodule
`default_nettype wire
